// ===== include/cpu_regs_pkg.sv
// Offsets, flag layout and reset values of the CPU register set
package cpu_regs_pkg;
  // Byte offsets on the register bus, one aligned word each
  localparam logic [7:0] OFF_DATA0      = 8'h00;
  localparam logic [7:0] OFF_DATA1      = 8'h04;
  localparam logic [7:0] OFF_DATA2      = 8'h08;
  localparam logic [7:0] OFF_DATA3      = 8'h0c;
  localparam logic [7:0] OFF_ADDR0      = 8'h10;
  localparam logic [7:0] OFF_ADDR1      = 8'h14;
  localparam logic [7:0] OFF_FRAME      = 8'h18;
  localparam logic [7:0] OFF_VTB        = 8'h1c;
  localparam logic [7:0] OFF_PC         = 8'h20;
  localparam logic [7:0] OFF_USP        = 8'h24;
  localparam logic [7:0] OFF_ISP        = 8'h28;
  localparam logic [7:0] OFF_SB         = 8'h2c;
  localparam logic [7:0] OFF_FLAGS      = 8'h30;
  localparam logic [7:0] OFF_ACTIVE_SP  = 8'h34;
  localparam logic [7:0] OFF_D0_LOWER   = 8'h38;
  localparam logic [7:0] OFF_D0_UPPER   = 8'h3c;
  localparam logic [7:0] OFF_D1_LOWER   = 8'h40;
  localparam logic [7:0] OFF_D1_UPPER   = 8'h44;
  localparam logic [7:0] OFF_DLONG0     = 8'h48;
  localparam logic [7:0] OFF_DLONG1     = 8'h4c;
  localparam logic [7:0] OFF_ALONG      = 8'h50;
  // Bank slot indices
  localparam int         NUM_BANKS      = 2;
  localparam int         BANK_SLOTS     = 7;
  localparam logic [2:0] SLOT_DATA0     = 3'h0;
  localparam logic [2:0] SLOT_DATA1     = 3'h1;
  localparam logic [2:0] SLOT_DATA2     = 3'h2;
  localparam logic [2:0] SLOT_DATA3     = 3'h3;
  localparam logic [2:0] SLOT_ADDR0     = 3'h4;
  localparam logic [2:0] SLOT_ADDR1     = 3'h5;
  localparam logic [2:0] SLOT_FRAME     = 3'h6;
  // Flag register layout
  localparam int         FLG_C          = 0;
  localparam int         FLG_D          = 1;
  localparam int         FLG_Z          = 2;
  localparam int         FLG_S          = 3;
  localparam int         FLG_B          = 4;
  localparam int         FLG_O          = 5;
  localparam int         FLG_I          = 6;
  localparam int         FLG_U          = 7;
  localparam int         FLG_IPL_LSB    = 8;
  localparam int         FLG_WIDTH      = 11;
  // Software interrupt numbers below this one switch to the interrupt stack
  localparam logic [5:0] SW_INT_SP_LIMIT = 6'h20;
  // ALU operand sizes
  localparam logic [1:0] SIZE_BYTE      = 2'h0;
  localparam logic [1:0] SIZE_WORD      = 2'h1;
  localparam logic [1:0] SIZE_LONG      = 2'h2;
  // Reset values
  localparam logic [15:0] RST_REG16     = 16'h0000;
  localparam logic [19:0] RST_REG20     = 20'h00000;
  localparam logic [10:0] RST_FLAGS     = 11'h000;
endpackage

// ===== logic/cpu_register_set_and_flags.sv
// CPU register set with two banks, flag register and AHB-Lite access
//
// Overview of operation
// RULE_01: Thirteen registers; data, address, frame banked twice
// RULE_02: Bank flag picks bank 0 or 1
// RULE_03: 16-bit data regs; regs 0,1 byte halves
// RULE_04: Data 2:0 and 3:1 form long pairs
// RULE_05: 16-bit address regs; 1:0 long pair
// RULE_06: Frame base is 16 bits wide
// RULE_07: Vector table base is 20 bits
// RULE_08: Program counter is 20 bits
// RULE_09: Active, user, interrupt stack pointers 16 bits
// RULE_10: Stack flag 0 interrupt, 1 user pointer
// RULE_11: Hardware ack or low software int clears stack flag
// RULE_12: Static base is 16 bits wide
// RULE_13: Flag register is 11 bits wide
// RULE_14: Carry flag captures ALU carry out
// RULE_15: Software keeps debug flag at zero
// RULE_16: Zero flag set on zero result
// RULE_17: Sign flag set on negative result
// RULE_18: Overflow flag set on overflow
// RULE_19: Interrupt enable flag gates maskable requests
// RULE_20: Any interrupt acknowledge clears enable flag
// RULE_21: Three-bit level; accept only higher priority
// RULE_22: Reserved flag bit written zero, reads zero
// RULE_23: Fixed flag bit positions for all accesses
//
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
module cpu_register_set_and_flags (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // ALU flag update
  input  wire logic        alu_update_in,
  input  wire logic [1:0]  alu_size_in,
  input  wire logic [31:0] alu_result_in,
  input  wire logic        alu_carry_in,
  input  wire logic        alu_overflow_in,
  // Interrupt events
  input  wire logic        hw_int_ack_in,
  input  wire logic        sw_int_in,
  input  wire logic [5:0]  sw_int_num_in,
  input  wire logic        int_req_in,
  input  wire logic [2:0]  int_req_level_in,
  output logic             int_accept_out,
  // Program counter load
  input  wire logic        pc_load_in,
  input  wire logic [19:0] pc_value_in,
  // State toward the datapath
  output logic      [10:0] flags_out,
  output logic      [19:0] pc_out,
  output logic      [19:0] vector_base_out
);

  function automatic logic res_zero(input logic [1:0] sz, input logic [31:0] r);
    case (sz)
      cpu_regs_pkg::SIZE_BYTE: res_zero = (r[7:0] == 8'h00);
      cpu_regs_pkg::SIZE_WORD: res_zero = (r[15:0] == 16'h0000);
      default:                 res_zero = (r == 32'h0000_0000);
    endcase
  endfunction

  function automatic logic res_sign(input logic [1:0] sz, input logic [31:0] r);
    case (sz)
      cpu_regs_pkg::SIZE_BYTE: res_sign = r[7];
      cpu_regs_pkg::SIZE_WORD: res_sign = r[15];
      default:                 res_sign = r[31];
    endcase
  endfunction

  // Register state
  logic [15:0] bank_q [cpu_regs_pkg::NUM_BANKS][cpu_regs_pkg::BANK_SLOTS]; // RULE_01
  logic [19:0] vtb_q;
  logic [19:0] pc_q;
  logic [15:0] usp_q;
  logic [15:0] isp_q;
  logic [15:0] sb_q;
  logic [10:0] flags_q;
  logic [10:0] flags_d;

  // Bus state
  logic        wr_pend_q;
  logic        rd_pend_q;
  logic [7:0]  addr_q;
  logic [31:0] rd_word;

  wire         accept   = hsel_in & htrans_in[1] & hready_in;
  wire         wr_fire  = wr_pend_q;
  wire         bsel     = flags_q[cpu_regs_pkg::FLG_B];                        // RULE_02
  wire         usel     = flags_q[cpu_regs_pkg::FLG_U];                        // RULE_10
  wire [15:0]  wd16     = hwdata_in[15:0];
  wire [7:0]   wd8      = hwdata_in[7:0];
  wire         wr_flags = wr_fire & (addr_q == cpu_regs_pkg::OFF_FLAGS);
  wire         wr_pc    = wr_fire & (addr_q == cpu_regs_pkg::OFF_PC);
  wire         any_ack  = hw_int_ack_in | sw_int_in;
  wire         sp_to_isp = hw_int_ack_in |
                           (sw_int_in & (sw_int_num_in < cpu_regs_pkg::SW_INT_SP_LIMIT));
  wire [2:0]   processor_priority_level      = flags_q[cpu_regs_pkg::FLG_IPL_LSB +: 3];
  wire         accept_d = int_req_in & flags_q[cpu_regs_pkg::FLG_I] &
                          (int_req_level_in > processor_priority_level);                            // RULE_19 RULE_21
  wire [15:0]  active_sp = usel ? usp_q : isp_q;                               // RULE_09 RULE_10

  // AHB address and data phase tracking; reads take one wait state so
  // a write in the preceding data phase is always visible
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_pend_q     <= 1'b0;
      rd_pend_q     <= 1'b0;
      addr_q        <= 8'h00;
      hreadyout_out <= 1'b1;
      hrdata_out    <= 32'h0000_0000;
    end else begin
      wr_pend_q <= accept & hwrite_in;
      rd_pend_q <= accept & ~hwrite_in;
      if (accept) begin
        addr_q <= haddr_in[7:0];
      end
      hreadyout_out <= ~(accept & ~hwrite_in);
      if (rd_pend_q) begin
        hrdata_out <= rd_word;
      end
    end
  end

  assign hresp_out = 1'b0;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (addr_q)
      cpu_regs_pkg::OFF_DATA0:     rd_word[15:0] = bank_q[bsel][cpu_regs_pkg::SLOT_DATA0];
      cpu_regs_pkg::OFF_DATA1:     rd_word[15:0] = bank_q[bsel][cpu_regs_pkg::SLOT_DATA1];
      cpu_regs_pkg::OFF_DATA2:     rd_word[15:0] = bank_q[bsel][cpu_regs_pkg::SLOT_DATA2];
      cpu_regs_pkg::OFF_DATA3:     rd_word[15:0] = bank_q[bsel][cpu_regs_pkg::SLOT_DATA3];
      cpu_regs_pkg::OFF_ADDR0:     rd_word[15:0] = bank_q[bsel][cpu_regs_pkg::SLOT_ADDR0];
      cpu_regs_pkg::OFF_ADDR1:     rd_word[15:0] = bank_q[bsel][cpu_regs_pkg::SLOT_ADDR1];
      cpu_regs_pkg::OFF_FRAME:     rd_word[15:0] = bank_q[bsel][cpu_regs_pkg::SLOT_FRAME];
      cpu_regs_pkg::OFF_VTB:       rd_word[19:0] = vtb_q;
      cpu_regs_pkg::OFF_PC:        rd_word[19:0] = pc_q;
      cpu_regs_pkg::OFF_USP:       rd_word[15:0] = usp_q;
      cpu_regs_pkg::OFF_ISP:       rd_word[15:0] = isp_q;
      cpu_regs_pkg::OFF_SB:        rd_word[15:0] = sb_q;
      cpu_regs_pkg::OFF_FLAGS:     rd_word[10:0] = flags_q;                  // RULE_22 RULE_23
      cpu_regs_pkg::OFF_ACTIVE_SP: rd_word[15:0] = active_sp;
      cpu_regs_pkg::OFF_D0_LOWER:  rd_word[7:0]  = bank_q[bsel][cpu_regs_pkg::SLOT_DATA0][7:0];
      cpu_regs_pkg::OFF_D0_UPPER:  rd_word[7:0]  = bank_q[bsel][cpu_regs_pkg::SLOT_DATA0][15:8];
      cpu_regs_pkg::OFF_D1_LOWER:  rd_word[7:0]  = bank_q[bsel][cpu_regs_pkg::SLOT_DATA1][7:0];
      cpu_regs_pkg::OFF_D1_UPPER:  rd_word[7:0]  = bank_q[bsel][cpu_regs_pkg::SLOT_DATA1][15:8];
      cpu_regs_pkg::OFF_DLONG0:    rd_word = {bank_q[bsel][cpu_regs_pkg::SLOT_DATA2],
                                              bank_q[bsel][cpu_regs_pkg::SLOT_DATA0]}; // RULE_04
      cpu_regs_pkg::OFF_DLONG1:    rd_word = {bank_q[bsel][cpu_regs_pkg::SLOT_DATA3],
                                              bank_q[bsel][cpu_regs_pkg::SLOT_DATA1]}; // RULE_04
      cpu_regs_pkg::OFF_ALONG:     rd_word = {bank_q[bsel][cpu_regs_pkg::SLOT_ADDR1],
                                              bank_q[bsel][cpu_regs_pkg::SLOT_ADDR0]}; // RULE_05
      default:                     rd_word = 32'h0000_0000;
    endcase
  end

  // Banked registers follow the bank flag in force at the write
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int b = 0; b < cpu_regs_pkg::NUM_BANKS; b++) begin
        for (int s = 0; s < cpu_regs_pkg::BANK_SLOTS; s++) begin
          bank_q[b][s] <= cpu_regs_pkg::RST_REG16;
        end
      end
    end else if (wr_fire) begin
      case (addr_q)
        cpu_regs_pkg::OFF_DATA0:    bank_q[bsel][cpu_regs_pkg::SLOT_DATA0] <= wd16; // RULE_03
        cpu_regs_pkg::OFF_DATA1:    bank_q[bsel][cpu_regs_pkg::SLOT_DATA1] <= wd16; // RULE_03
        cpu_regs_pkg::OFF_DATA2:    bank_q[bsel][cpu_regs_pkg::SLOT_DATA2] <= wd16;
        cpu_regs_pkg::OFF_DATA3:    bank_q[bsel][cpu_regs_pkg::SLOT_DATA3] <= wd16;
        cpu_regs_pkg::OFF_ADDR0:    bank_q[bsel][cpu_regs_pkg::SLOT_ADDR0] <= wd16; // RULE_05
        cpu_regs_pkg::OFF_ADDR1:    bank_q[bsel][cpu_regs_pkg::SLOT_ADDR1] <= wd16; // RULE_05
        cpu_regs_pkg::OFF_FRAME:    bank_q[bsel][cpu_regs_pkg::SLOT_FRAME] <= wd16; // RULE_06
        cpu_regs_pkg::OFF_D0_LOWER: bank_q[bsel][cpu_regs_pkg::SLOT_DATA0][7:0]  <= wd8; // RULE_03
        cpu_regs_pkg::OFF_D0_UPPER: bank_q[bsel][cpu_regs_pkg::SLOT_DATA0][15:8] <= wd8; // RULE_03
        cpu_regs_pkg::OFF_D1_LOWER: bank_q[bsel][cpu_regs_pkg::SLOT_DATA1][7:0]  <= wd8; // RULE_03
        cpu_regs_pkg::OFF_D1_UPPER: bank_q[bsel][cpu_regs_pkg::SLOT_DATA1][15:8] <= wd8; // RULE_03
        cpu_regs_pkg::OFF_DLONG0: begin
          bank_q[bsel][cpu_regs_pkg::SLOT_DATA0] <= hwdata_in[15:0];  // RULE_04
          bank_q[bsel][cpu_regs_pkg::SLOT_DATA2] <= hwdata_in[31:16]; // RULE_04
        end
        cpu_regs_pkg::OFF_DLONG1: begin
          bank_q[bsel][cpu_regs_pkg::SLOT_DATA1] <= hwdata_in[15:0];  // RULE_04
          bank_q[bsel][cpu_regs_pkg::SLOT_DATA3] <= hwdata_in[31:16]; // RULE_04
        end
        cpu_regs_pkg::OFF_ALONG: begin
          bank_q[bsel][cpu_regs_pkg::SLOT_ADDR0] <= hwdata_in[15:0];  // RULE_05
          bank_q[bsel][cpu_regs_pkg::SLOT_ADDR1] <= hwdata_in[31:16]; // RULE_05
        end
        default: ;
      endcase
    end
  end

  // Shared registers; a datapath load of the counter beats a bus write
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      vtb_q <= cpu_regs_pkg::RST_REG20;
      pc_q  <= cpu_regs_pkg::RST_REG20;
      usp_q <= cpu_regs_pkg::RST_REG16;
      isp_q <= cpu_regs_pkg::RST_REG16;
      sb_q  <= cpu_regs_pkg::RST_REG16;
    end else begin
      if (wr_fire && addr_q == cpu_regs_pkg::OFF_VTB) vtb_q <= hwdata_in[19:0]; // RULE_07
      if (pc_load_in) begin
        pc_q <= pc_value_in;                                                      // RULE_08
      end else if (wr_pc) begin
        pc_q <= hwdata_in[19:0];                                                  // RULE_08
      end
      if (wr_fire && addr_q == cpu_regs_pkg::OFF_USP) usp_q <= wd16;             // RULE_09
      if (wr_fire && addr_q == cpu_regs_pkg::OFF_ISP) isp_q <= wd16;             // RULE_09
      if (wr_fire && addr_q == cpu_regs_pkg::OFF_ACTIVE_SP) begin
        if (usel) begin
          usp_q <= wd16;                                                          // RULE_10
        end else begin
          isp_q <= wd16;                                                          // RULE_10
        end
      end
      if (wr_fire && addr_q == cpu_regs_pkg::OFF_SB) sb_q <= wd16;               // RULE_12
    end
  end

  // Hardware events are applied after the bus write so they win
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = hwdata_in[cpu_regs_pkg::FLG_WIDTH-1:0];                         // RULE_13 RULE_23
    end
    if (alu_update_in) begin
      flags_d[cpu_regs_pkg::FLG_C] = alu_carry_in;                              // RULE_14
      flags_d[cpu_regs_pkg::FLG_Z] = res_zero(alu_size_in, alu_result_in);     // RULE_16
      flags_d[cpu_regs_pkg::FLG_S] = res_sign(alu_size_in, alu_result_in);     // RULE_17
      flags_d[cpu_regs_pkg::FLG_O] = alu_overflow_in;                           // RULE_18
    end
    if (any_ack) begin
      flags_d[cpu_regs_pkg::FLG_I] = 1'b0;                                      // RULE_20
    end
    if (sp_to_isp) begin
      flags_d[cpu_regs_pkg::FLG_U] = 1'b0;                                      // RULE_11
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      flags_q        <= cpu_regs_pkg::RST_FLAGS;
      int_accept_out <= 1'b0;
    end else begin
      flags_q        <= flags_d;
      int_accept_out <= accept_d;                                                // RULE_19 RULE_21
    end
  end

  assign flags_out       = flags_q;
  assign pc_out          = pc_q;
  assign vector_base_out = vtb_q;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  AST_ACK_CLEARS_ENABLE: assert property ( // RULE_20
    any_ack |=> !flags_q[cpu_regs_pkg::FLG_I])
    else $error("Interrupt enable flag not cleared by acknowledge");

  AST_HW_ACK_ISP: assert property ( // RULE_11
    hw_int_ack_in |=> !flags_q[cpu_regs_pkg::FLG_U] && active_sp == isp_q)
    else $error("Stack select not cleared by hardware acknowledge");

  AST_HIGH_SW_KEEPS_U: assert property ( // RULE_11
    sw_int_in && sw_int_num_in >= 6'h20 && !hw_int_ack_in && !wr_flags
    |=> flags_q[cpu_regs_pkg::FLG_U] == $past(flags_q[cpu_regs_pkg::FLG_U]))
    else $error("High software interrupt changed stack select");

  AST_CARRY_CAPTURE: assert property ( // RULE_14
    alu_update_in |=> flags_q[cpu_regs_pkg::FLG_C] == $past(alu_carry_in))
    else $error("Carry flag does not follow ALU carry");

  AST_ZERO_WORD: assert property ( // RULE_16
    alu_update_in && alu_size_in == 2'h1 |=>
    flags_q[cpu_regs_pkg::FLG_Z] == ($past(alu_result_in[15:0]) == 16'h0000))
    else $error("Zero flag wrong for word result");

  AST_SIGN_BYTE: assert property ( // RULE_17
    alu_update_in && alu_size_in == 2'h0 |=>
    flags_q[cpu_regs_pkg::FLG_S] == $past(alu_result_in[7]))
    else $error("Sign flag wrong for byte result");

  AST_OVERFLOW: assert property ( // RULE_18
    alu_update_in |=> flags_q[cpu_regs_pkg::FLG_O] == $past(alu_overflow_in))
    else $error("Overflow flag does not follow ALU");

  AST_NO_ACCEPT_MASKED: assert property ( // RULE_19
    !flags_q[cpu_regs_pkg::FLG_I] |=> !int_accept_out)
    else $error("Request accepted while interrupts disabled");

  AST_LEVEL_COMPARE: assert property ( // RULE_21
    int_req_in && int_req_level_in <= processor_priority_level |=> !int_accept_out)
    else $error("Request accepted at or below processor level");

  AST_READ_WAIT: assert property (
    accept && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
    else $error("Read does not take exactly one wait state");

  AST_WRITE_NO_WAIT: assert property (
    accept && hwrite_in |=> hreadyout_out)
    else $error("Write inserted a wait state");

  AST_ACCEPT_LEVEL: assert property ( // RULE_19 RULE_21
    int_accept_out |-> $past(flags_q[cpu_regs_pkg::FLG_I]) && $past(int_req_level_in) > $past(processor_priority_level))
    else $error("Request accepted without enable or higher level");

  AST_FLAGS_WRITE: assert property ( // RULE_13 RULE_23
    wr_flags && !alu_update_in && !any_ack |=> flags_q == $past(hwdata_in[10:0]))
    else $error("Flag register write did not land");

  AST_PC_LOAD: assert property ( // RULE_08
    pc_load_in |=> pc_q == $past(pc_value_in))
    else $error("Program counter load did not land");

  AST_SP_ROUTE: assert property ( // RULE_10
    wr_fire && addr_q == cpu_regs_pkg::OFF_ACTIVE_SP |=>
    ($past(usel) ? usp_q : isp_q) == $past(wd16))
    else $error("Active stack pointer write went to the wrong pointer");

  AST_STATIC_BASE: assert property ( // RULE_12
    wr_fire && addr_q == cpu_regs_pkg::OFF_SB |=> sb_q == $past(wd16))
    else $error("Static base write did not land");

  COV_READ:   cover property (accept && !hwrite_in ##2 hreadyout_out);
  COV_LOW_SW: cover property (sw_int_in && sp_to_isp);
  COV_WRITE:  cover property (wr_flags);
  COV_BANK1:  cover property (wr_fire && bsel);
  COV_ACCEPT: cover property (int_accept_out);

endmodule // cpu_register_set_and_flags

// ===== verif/cpu_register_set_and_flags_bench.sv
// Self-checking bench for the banked CPU register set and flag register
`timescale 1ns/1ns
module cpu_register_set_and_flags_bench;
  logic        clk_in;
  logic        rst_b_in;
  logic        hsel_in;
  logic [31:0] haddr_in;
  logic [1:0]  htrans_in;
  logic        hwrite_in;
  logic [2:0]  hsize_in;
  logic [31:0] hwdata_in;
  logic        hready_in;
  logic [31:0] hrdata_out;
  logic        hreadyout_out;
  logic        hresp_out;
  logic        alu_update_in;
  logic [1:0]  alu_size_in;
  logic [31:0] alu_result_in;
  logic        alu_carry_in;
  logic        alu_overflow_in;
  logic        hw_int_ack_in;
  logic        sw_int_in;
  logic [5:0]  sw_int_num_in;
  logic        int_req_in;
  logic [2:0]  int_req_level_in;
  logic        int_accept_out;
  logic        pc_load_in;
  logic [19:0] pc_value_in;
  logic [10:0] flags_out;
  logic [19:0] pc_out;
  logic [19:0] vector_base_out;
  int          err_total;
  int          comparisons;
  logic [31:0] rd;

  assign hready_in = hreadyout_out;

  cpu_register_set_and_flags dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .alu_update_in(alu_update_in), .alu_size_in(alu_size_in),
    .alu_result_in(alu_result_in), .alu_carry_in(alu_carry_in),
    .alu_overflow_in(alu_overflow_in), .hw_int_ack_in(hw_int_ack_in), .sw_int_in(sw_int_in),
    .sw_int_num_in(sw_int_num_in), .int_req_in(int_req_in),
    .int_req_level_in(int_req_level_in), .int_accept_out(int_accept_out),
    .pc_load_in(pc_load_in), .pc_value_in(pc_value_in), .flags_out(flags_out),
    .pc_out(pc_out), .vector_base_out(vector_base_out));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One AHB single transfer; entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] data);
    hsel_in   <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    hsize_in  <= 3'h2;
    haddr_in  <= {24'h000000, a};
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    data = hrdata_out;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, a, wd, dummy);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h00000000, v);
    check(name, v, exp);
  endtask

  // Pulse one ALU update and look at the flags one cycle later
  task automatic alu(input logic [1:0] sz, input logic [31:0] res, input logic c,
                     input logic o, input logic [10:0] exp);
    alu_update_in   <= 1'b1;
    alu_size_in     <= sz;
    alu_result_in   <= res;
    alu_carry_in    <= c;
    alu_overflow_in <= o;
    @(posedge clk_in);
    alu_update_in <= 1'b0;
    @(posedge clk_in);
    check("flags_alu", {21'h0, flags_out}, {21'h0, exp});
  endtask

  // Pulse an interrupt event after loading the flags over the bus
  task automatic evt(input logic hw, input logic [5:0] num, input logic [10:0] exp);
    wr(cpu_regs_pkg::OFF_FLAGS, 32'h000003c0);
    hw_int_ack_in <= hw;
    sw_int_in     <= ~hw;
    sw_int_num_in <= num;
    @(posedge clk_in);
    hw_int_ack_in <= 1'b0;
    sw_int_in     <= 1'b0;
    @(posedge clk_in);
    check("flags_event", {21'h0, flags_out}, {21'h0, exp});
  endtask

  task automatic req(input logic [2:0] lvl, input logic exp);
    int_req_in       <= 1'b1;
    int_req_level_in <= lvl;
    @(posedge clk_in);
    @(posedge clk_in);
    check("int_accept", {31'h0, int_accept_out}, {31'h0, exp});
    int_req_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic test_reset_and_unmapped();
    for (int a = 0; a <= 'h50; a += 4) rd_chk("reset_value", 8'(a), 32'h0);
    wr(8'h54, 32'h12345678);
    rd_chk("unmapped", 8'h54, 32'h0);
    wr(8'hfc, 32'hffffffff);
    rd_chk("unmapped_top", 8'hfc, 32'h0);
    check("hresp", {31'h0, hresp_out}, 32'h0);
  endtask

  task automatic test_alu_flags();
    alu(cpu_regs_pkg::SIZE_WORD, 32'h00010000, 1'b1, 1'b0, 11'h005);
    alu(cpu_regs_pkg::SIZE_WORD, 32'h00008000, 1'b0, 1'b1, 11'h028);
    alu(cpu_regs_pkg::SIZE_BYTE, 32'h00000100, 1'b0, 1'b0, 11'h004);
    alu(cpu_regs_pkg::SIZE_BYTE, 32'h00000080, 1'b1, 1'b0, 11'h009);
    alu(cpu_regs_pkg::SIZE_LONG, 32'h80000000, 1'b0, 1'b0, 11'h008);
    alu(cpu_regs_pkg::SIZE_LONG, 32'h00010000, 1'b0, 1'b0, 11'h000);
  endtask

  task automatic test_banks();
    wr(cpu_regs_pkg::OFF_DATA0, 32'h0000a0a0);
    wr(cpu_regs_pkg::OFF_FRAME, 32'h0000f0f0);
    wr(cpu_regs_pkg::OFF_FLAGS, 32'h00000010);
    rd_chk("bank1_data0", cpu_regs_pkg::OFF_DATA0, 32'h0);
    wr(cpu_regs_pkg::OFF_DATA0, 32'h0000b1b1);
    rd_chk("bank1_data0_new", cpu_regs_pkg::OFF_DATA0, 32'h0000b1b1);
    rd_chk("bank1_frame", cpu_regs_pkg::OFF_FRAME, 32'h0);
    wr(cpu_regs_pkg::OFF_FLAGS, 32'h00000000);
    rd_chk("bank0_data0", cpu_regs_pkg::OFF_DATA0, 32'h0000a0a0);
    rd_chk("bank0_frame", cpu_regs_pkg::OFF_FRAME, 32'h0000f0f0);
  endtask

  task automatic test_halves_pairs();
    wr(cpu_regs_pkg::OFF_DATA1, 32'hffff5678);
    rd_chk("data1_width", cpu_regs_pkg::OFF_DATA1, 32'h00005678);
    rd_chk("d1_lower", cpu_regs_pkg::OFF_D1_LOWER, 32'h00000078);
    rd_chk("d1_upper", cpu_regs_pkg::OFF_D1_UPPER, 32'h00000056);
    wr(cpu_regs_pkg::OFF_D0_UPPER, 32'h000000c3);
    wr(cpu_regs_pkg::OFF_D0_LOWER, 32'h0000003c);
    rd_chk("d0_join", cpu_regs_pkg::OFF_DATA0, 32'h0000c33c);
    wr(cpu_regs_pkg::OFF_DLONG0, 32'haabbccdd);
    rd_chk("pair0_low", cpu_regs_pkg::OFF_DATA0, 32'h0000ccdd);
    rd_chk("pair0_high", cpu_regs_pkg::OFF_DATA2, 32'h0000aabb);
    wr(cpu_regs_pkg::OFF_DATA3, 32'h00001357);
    rd_chk("pair1", cpu_regs_pkg::OFF_DLONG1, 32'h13575678);
    wr(cpu_regs_pkg::OFF_ALONG, 32'h9abc4321);
    rd_chk("along_low", cpu_regs_pkg::OFF_ADDR0, 32'h00004321);
    rd_chk("along_high", cpu_regs_pkg::OFF_ADDR1, 32'h00009abc);
  endtask

  task automatic test_widths_pc();
    wr(cpu_regs_pkg::OFF_VTB, 32'hffffffff);
    rd_chk("vtb", cpu_regs_pkg::OFF_VTB, 32'h000fffff);
    check("vector_base_out", {12'h0, vector_base_out}, 32'h000fffff);
    wr(cpu_regs_pkg::OFF_SB, 32'hffffffff);
    rd_chk("sb", cpu_regs_pkg::OFF_SB, 32'h0000ffff);
    wr(cpu_regs_pkg::OFF_PC, 32'hfff12345);
    rd_chk("pc", cpu_regs_pkg::OFF_PC, 32'h00012345);
    pc_load_in  <= 1'b1;
    pc_value_in <= 20'habcde;
    @(posedge clk_in);
    pc_load_in <= 1'b0;
    @(posedge clk_in);
    check("pc_out", {12'h0, pc_out}, 32'h000abcde);
    wr(cpu_regs_pkg::OFF_FLAGS, 32'h000007ed);
    rd_chk("flags_width", cpu_regs_pkg::OFF_FLAGS, 32'h000007ed);
    wr(cpu_regs_pkg::OFF_FLAGS, 32'h00000000);
  endtask

  task automatic test_stack_select();
    wr(cpu_regs_pkg::OFF_ACTIVE_SP, 32'hffffbeef);
    rd_chk("isp_via_sp", cpu_regs_pkg::OFF_ISP, 32'h0000beef);
    wr(cpu_regs_pkg::OFF_FLAGS, 32'h00000080);
    wr(cpu_regs_pkg::OFF_ACTIVE_SP, 32'h00001111);
    rd_chk("usp_via_sp", cpu_regs_pkg::OFF_USP, 32'h00001111);
    rd_chk("isp_kept", cpu_regs_pkg::OFF_ISP, 32'h0000beef);
    rd_chk("sp_is_usp", cpu_regs_pkg::OFF_ACTIVE_SP, 32'h00001111);
  endtask

  task automatic test_interrupts();
    wr(cpu_regs_pkg::OFF_FLAGS, 32'h000003c0);
    req(3'h4, 1'b1);
    req(3'h3, 1'b0);
    req(3'h2, 1'b0);
    wr(cpu_regs_pkg::OFF_FLAGS, 32'h00000380);
    req(3'h7, 1'b0);
    evt(1'b1, 6'h00, 11'h300);
    evt(1'b0, 6'h1f, 11'h300);
    evt(1'b0, 6'h20, 11'h380);
  endtask

  // Whole run needs a few hundred cycles; far more means a hung handshake
  initial begin
    #(40 * 20000);
    err_total++;
    stop_test();
  end

  initial begin
    err_total = 0;
    comparisons = 0;
    rst_b_in = 1'b0;
    hsel_in = 1'b0;
    haddr_in = 32'h0;
    htrans_in = 2'h0;
    hwrite_in = 1'b0;
    hsize_in = 3'h0;
    hwdata_in = 32'h0;
    alu_update_in = 1'b0;
    alu_size_in = 2'h0;
    alu_result_in = 32'h0;
    alu_carry_in = 1'b0;
    alu_overflow_in = 1'b0;
    hw_int_ack_in = 1'b0;
    sw_int_in = 1'b0;
    sw_int_num_in = 6'h00;
    int_req_in = 1'b0;
    int_req_level_in = 3'h0;
    pc_load_in = 1'b0;
    pc_value_in = 20'h00000;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    check("flags_reset", {21'h0, flags_out}, 32'h0);
    test_reset_and_unmapped();
    test_alu_flags();
    test_banks();
    test_halves_pairs();
    test_widths_pc();
    test_stack_select();
    test_interrupts();
    stop_test();
  end
endmodule // cpu_register_set_and_flags_bench
